/* printer_port_pkg.sv */
// Shared constants and carrier types for the bidirectional printer port.
package printer_port_pkg;

    // Register selects on the two low address lines.
    localparam logic [1:0] ADDR_DATA_PORT   = 2'h0;
    localparam logic [1:0] ADDR_STATUS_KEY  = 2'h1;
    localparam logic [1:0] ADDR_CONTROL     = 2'h2;

    // Keys written to the direction key register.
    localparam logic [7:0] KEY_INPUT_MODE   = 8'hAA;
    localparam logic [7:0] KEY_OUTPUT_MODE  = 8'h55;

    // Control field positions: handshake, interrupt enable and direction.
    localparam int CTL_STROBE_BIT   = 0;
    localparam int CTL_LINEFEED_BIT = 1;
    localparam int CTL_INIT_BIT     = 2;
    localparam int CTL_CHOOSE_BIT   = 3;
    localparam int CTL_IRQ_EN_BIT   = 4;
    localparam int CTL_DIR_BIT      = 5;

    // Status field positions.
    localparam int STS_IRQ_STATE_BIT = 2;

    // Values after reset and fixed read bits.
    localparam logic [5:0] CONTROL_RESET    = 6'h00;
    localparam logic [7:0] DATA_RESET       = 8'h00;
    localparam logic [1:0] STATUS_ONES      = 2'h3;
    localparam logic [2:0] READBACK_ONES    = 3'h7;
    localparam logic [7:0] UNMAPPED_READ    = 8'hFF;

    // Printer status inputs as they arrive at the pins.
    typedef struct packed {
        logic busy;
        logic ack_n;
        logic paper_out_line;
        logic online_line;
        logic fault_n;
    } status_in_t;

    // Handshake outputs towards the printer.
    typedef struct packed {
        logic printer_choose_line_n;
        logic printer_init;
        logic line_feed_request_n;
        logic strobe_n;
    } handshake_out_t;

endpackage

/* pin_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module pin_sync #(
    parameter int          WIDTH = 1,
    parameter logic [31:0] INIT  = 32'h0000_0000
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_nrst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_ff <= INIT[WIDTH-1:0];
            sync_ff <= INIT[WIDTH-1:0];
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule

/* bidir_printer_port.sv */
// Bidirectional printer port: host strobe bus, registers and printer pins.
// Function
// - Address 00 data port; 01 key write, status read; 10 control write, readback.
// - Reading status deasserts the printer interrupt output unless an acknowledge falling edge comes in the same cycle.
// - Software variant, direction pin high: control bit 5 picks direction, 1 input.
// - Software variant, direction pin low: key AA gives input, 55 output.
// - Output mode drives written byte; input mode reads present data line levels.
// - Reset: output mode, data low, strobe/linefeed/choose high, printer init low.
// - Status bit 2 clears on acknowledge falling edge, which wins over a status read in the same cycle; status read sets it.
// - Status bits 1-0 read one; bits 3-6 show fault, online, paper, ack.
// - Status bit 7 shows busy input inverted.
// - Readback shows pin states, interrupt enable, ones in bits 7-5, any direction.
// - Control bits 0,1,3 drive active-low outputs; bit 2 drives printer init.
// - Control bit 4 enables interrupt output; bits 7-6 ignored.
// - Key and bit 5 only on software variant; fixed variant follows direction pin.
`timescale 1ns/1ps
module bidir_printer_port #(
    parameter bit SOFT_DIR = 1'b1
) (
    input  wire logic                             i_core_clk,
    input  wire logic                             i_nrst,
    input  wire logic                             i_cs_n,
    input  wire logic [1:0]                       i_addr,
    input  wire logic                             i_iow_n,
    input  wire logic                             i_ior_n,
    input  wire logic [7:0]                       i_d,
    output logic      [7:0]                       o_d,
    output logic                                  o_d_oe,
    input  wire logic                             i_direction_pin,
    input  wire logic [7:0]                       i_port_data_lines,
    output logic      [7:0]                       o_port_data_lines,
    output logic                                  o_port_data_lines_oe,
    input  wire printer_port_pkg::status_in_t     i_status,
    output printer_port_pkg::handshake_out_t      o_handshake,
    output logic                                  o_printer_irq_out
);
    // Synchronised pin levels.
    logic                         cs_n_s;
    logic                         ior_n_s;
    logic                         iow_n_s;
    logic                         dir_pin_s;
    logic [1:0]                   addr_s;
    logic [7:0]                   d_s;
    logic [7:0]                   pd_s;
    printer_port_pkg::status_in_t sts_s;

    pin_sync #(.WIDTH(3), .INIT(32'h0000_0007)) u_strobe_sync (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_async    ({i_cs_n, i_ior_n, i_iow_n}),
        .o_sync     ({cs_n_s, ior_n_s, iow_n_s})
    );

    // The acknowledge bit starts high, its idle level, so that reset makes no false edge.
    pin_sync #(.WIDTH(24), .INIT(32'h0000_0008)) u_data_sync (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_async    ({i_direction_pin, i_addr, i_d, i_port_data_lines, i_status}),
        .o_sync     ({dir_pin_s, addr_s, d_s, pd_s, sts_s})
    );

    // Previous synchronised values for edge detection and write capture.
    logic       cs_n_q_ff;
    logic       ior_n_q_ff;
    logic       iow_n_q_ff;
    logic       ack_n_q_ff;
    logic [1:0] addr_q_ff;
    logic [7:0] d_q_ff;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cs_n_q_ff  <= 1'b1;
            ior_n_q_ff <= 1'b1;
            iow_n_q_ff <= 1'b1;
            ack_n_q_ff <= 1'b1;
            addr_q_ff  <= 2'h0;
            d_q_ff     <= 8'h00;
        end else begin
            cs_n_q_ff  <= cs_n_s;
            ior_n_q_ff <= ior_n_s;
            iow_n_q_ff <= iow_n_s;
            ack_n_q_ff <= sts_s.ack_n;
            addr_q_ff  <= addr_s;
            d_q_ff     <= d_s;
        end
    end

    // Bus events: a read is taken as the strobe falls, a write as it rises.
    logic rd_start;
    logic wr_end;
    logic ack_fall;
    assign rd_start = !cs_n_s && !ior_n_s && ior_n_q_ff;
    assign wr_end   = !cs_n_q_ff && iow_n_s && !iow_n_q_ff;
    assign ack_fall = ack_n_q_ff && !sts_s.ack_n;

    // Register state.
    logic [5:0] ctl_ff;
    logic [5:0] nxt_ctl;
    logic       key_input_ff;
    logic       nxt_key_input;
    logic [7:0] port_ff;
    logic [7:0] nxt_port;
    logic       no_irq_ff;
    logic       nxt_no_irq;
    logic [7:0] rd_data_ff;
    logic [7:0] nxt_rd_data;
    logic       input_mode;
    logic [7:0] status_val;
    logic [7:0] readback_val;

    // Builds the status byte from live printer inputs.
    function automatic logic [7:0] status_byte(input printer_port_pkg::status_in_t s,
                                               input logic no_irq);
        status_byte = {!s.busy, s.ack_n, s.paper_out_line, s.online_line, s.fault_n,
                       no_irq, printer_port_pkg::STATUS_ONES};
    endfunction

    // Direction select for both variants.
    always_comb begin
        if (!SOFT_DIR) begin
            input_mode = dir_pin_s;
        end else if (dir_pin_s) begin
            input_mode = ctl_ff[printer_port_pkg::CTL_DIR_BIT];
        end else begin
            input_mode = key_input_ff;
        end
    end

    // Read values for status and command readback.
    always_comb begin
        status_val   = status_byte(sts_s, no_irq_ff);
        readback_val = {printer_port_pkg::READBACK_ONES, ctl_ff[4:0]};
    end

    // Next values of all registers.
    always_comb begin
        nxt_ctl       = ctl_ff;
        nxt_key_input = key_input_ff;
        nxt_port      = port_ff;
        nxt_no_irq    = no_irq_ff;
        nxt_rd_data   = rd_data_ff;
        if (wr_end) begin
            case (addr_q_ff)
                printer_port_pkg::ADDR_DATA_PORT: begin
                    nxt_port = d_q_ff;
                end
                printer_port_pkg::ADDR_STATUS_KEY: begin
                    if (SOFT_DIR && d_q_ff == printer_port_pkg::KEY_INPUT_MODE) begin
                        nxt_key_input = 1'b1;
                    end else if (SOFT_DIR && d_q_ff == printer_port_pkg::KEY_OUTPUT_MODE) begin
                        nxt_key_input = 1'b0;
                    end
                end
                printer_port_pkg::ADDR_CONTROL: begin
                    nxt_ctl = d_q_ff[5:0];
                    if (!SOFT_DIR) begin
                        nxt_ctl[printer_port_pkg::CTL_DIR_BIT] = 1'b0;
                    end
                end
                default: begin
                    nxt_ctl = ctl_ff;
                end
            endcase
        end
        if (rd_start) begin
            case (addr_s)
                printer_port_pkg::ADDR_DATA_PORT: begin
                    nxt_rd_data = input_mode ? pd_s : port_ff;
                end
                printer_port_pkg::ADDR_STATUS_KEY: begin
                    nxt_rd_data = status_val;
                    nxt_no_irq  = 1'b1;
                end
                printer_port_pkg::ADDR_CONTROL: begin
                    nxt_rd_data = readback_val;
                end
                default: begin
                    nxt_rd_data = printer_port_pkg::UNMAPPED_READ;
                end
            endcase
        end
        if (ack_fall) begin
            nxt_no_irq = 1'b0;
        end
    end

    // Registers; reset leaves the port driving zeros with outputs idle.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctl_ff       <= printer_port_pkg::CONTROL_RESET;
            key_input_ff <= 1'b0;
            port_ff      <= printer_port_pkg::DATA_RESET;
            no_irq_ff    <= 1'b1;
            rd_data_ff   <= 8'h00;
        end else begin
            ctl_ff       <= nxt_ctl;
            key_input_ff <= nxt_key_input;
            port_ff      <= nxt_port;
            no_irq_ff    <= nxt_no_irq;
            rd_data_ff   <= nxt_rd_data;
        end
    end

    // Pin outputs.
    always_comb begin
        o_d                  = rd_data_ff;
        o_d_oe               = !cs_n_s && !ior_n_s;
        o_port_data_lines    = port_ff;
        o_port_data_lines_oe = !input_mode;
        o_handshake.strobe_n              = !ctl_ff[printer_port_pkg::CTL_STROBE_BIT];
        o_handshake.line_feed_request_n   = !ctl_ff[printer_port_pkg::CTL_LINEFEED_BIT];
        o_handshake.printer_init          = ctl_ff[printer_port_pkg::CTL_INIT_BIT];
        o_handshake.printer_choose_line_n = !ctl_ff[printer_port_pkg::CTL_CHOOSE_BIT];
        o_printer_irq_out = !no_irq_ff && ctl_ff[printer_port_pkg::CTL_IRQ_EN_BIT];
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_status_read;
        rd_start && addr_s == printer_port_pkg::ADDR_STATUS_KEY && !ack_fall;
    endsequence

    sequence s_ack_edge;
        $fell(sts_s.ack_n);
    endsequence

    status_read_irq_a: assert property (s_status_read |=> !o_printer_irq_out)
        else $error("Interrupt output stayed high after status read.");
    ack_pending_a: assert property (s_ack_edge |=> !no_irq_ff)
        else $error("Acknowledge edge did not mark pending.");
    status_sets_a: assert property (s_status_read |=> no_irq_ff)
        else $error("Status read did not clear pending.");
    key_input_a: assert property (SOFT_DIR && wr_end && addr_q_ff == 2'h1 && d_q_ff == 8'hAA
                                  ##1 !dir_pin_s |-> !o_port_data_lines_oe)
        else $error("Key AA did not select input mode.");
    key_output_a: assert property (SOFT_DIR && wr_end && addr_q_ff == 2'h1 && d_q_ff == 8'h55
                                   ##1 !dir_pin_s |-> o_port_data_lines_oe)
        else $error("Key 55 did not select output mode.");
    ctl_dir_a: assert property (SOFT_DIR && dir_pin_s |-> o_port_data_lines_oe == !ctl_ff[5])
        else $error("Control bit 5 does not set direction.");
    fixed_dir_a: assert property (!SOFT_DIR |-> o_port_data_lines_oe == !dir_pin_s)
        else $error("Fixed variant ignores direction pin.");
    port_write_a: assert property (wr_end && addr_q_ff == 2'h0 |=> o_port_data_lines == $past(d_q_ff))
        else $error("Data port write not driven to lines.");
    status_read_a: assert property (s_status_read |=> o_d[1:0] == 2'h3
                                    && o_d[7] == !$past(sts_s.busy))
        else $error("Status byte fixed bits or busy wrong.");
    readback_a: assert property (rd_start && addr_s == 2'h2 |=> o_d[7:5] == 3'h7
                                 && o_d[0] == !o_handshake.strobe_n)
        else $error("Readback does not match pins.");
    irq_gate_a: assert property (o_printer_irq_out |-> ctl_ff[4] && !no_irq_ff)
        else $error("Interrupt output without pending and enable.");
    ctl_pins_a: assert property (wr_end && addr_q_ff == 2'h2 |=> o_handshake.printer_init
                                 == $past(d_q_ff[2]) && o_handshake.strobe_n == !$past(d_q_ff[0]))
        else $error("Control write did not set handshake pins.");
endmodule

/* printer_model.sv */
// Printer-side partner model: data line levels, status lines and acknowledge.
`timescale 1ns/1ps
module printer_model (
    input  wire logic                    i_core_clk,
    input  wire logic                    i_dev_oe,
    input  wire logic [7:0]              i_dev_data,
    output logic      [7:0]              o_lines,
    output printer_port_pkg::status_in_t o_status
);
    logic [7:0] drive_val;
    // The printer drives the lines only while the port has released them.
    assign o_lines = i_dev_oe ? i_dev_data : drive_val;
    // Idle printer: ready, online, no fault, acknowledge high.
    initial begin
        drive_val = 8'h00;
        o_status = 5'h0B;
    end
    // Presents a byte on the released data lines.
    task automatic present(input logic [7:0] b);
        @(negedge i_core_clk);
        drive_val = b;
    endtask
    // New status levels; acknowledge stays high so no edge is made here.
    task automatic set_status(input logic [4:0] s);
        @(negedge i_core_clk);
        o_status = s | 5'h08;
    endtask
    // Acknowledge level; the caller holds a low for many cycles.
    task automatic set_ack(input logic lvl);
        @(negedge i_core_clk);
        o_status.ack_n = lvl;
    endtask
endmodule

/* tb.sv */
// Self-checking bench for the bidirectional printer port.
`timescale 1ns/1ps
module tb;
    logic       clk, nrst, cs_n, iow_n, ior_n, dir_pin;
    logic [1:0] addr;
    logic [7:0] din, dout, dout2, pd_in, pd_out, rd_val, v;
    logic       dout_oe, pd_oe, pd_oe2, irq, irq2;
    printer_port_pkg::status_in_t     sts;
    printer_port_pkg::handshake_out_t hs;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    bidir_printer_port #(.SOFT_DIR(1'b1)) bidir_printer_port_inst (
        .i_core_clk(clk), .i_nrst(nrst), .i_cs_n(cs_n), .i_addr(addr),
        .i_iow_n(iow_n), .i_ior_n(ior_n), .i_d(din), .o_d(dout), .o_d_oe(dout_oe),
        .i_direction_pin(dir_pin), .i_port_data_lines(pd_in),
        .o_port_data_lines(pd_out), .o_port_data_lines_oe(pd_oe),
        .i_status(sts), .o_handshake(hs), .o_printer_irq_out(irq));
    // Fixed-direction variant sharing the same bus, watched for direction, readback and interrupt.
    bidir_printer_port #(.SOFT_DIR(1'b0)) bidir_printer_port_fix_inst (
        .i_core_clk(clk), .i_nrst(nrst), .i_cs_n(cs_n), .i_addr(addr),
        .i_iow_n(iow_n), .i_ior_n(ior_n), .i_d(din), .o_d(dout2), .o_d_oe(),
        .i_direction_pin(dir_pin), .i_port_data_lines(pd_in),
        .o_port_data_lines(), .o_port_data_lines_oe(pd_oe2),
        .i_status(sts), .o_handshake(), .o_printer_irq_out(irq2));
    printer_model printer_model_inst (.i_core_clk(clk), .i_dev_oe(pd_oe),
        .i_dev_data(pd_out), .o_lines(pd_in), .o_status(sts));

    // Compares one value and counts the outcome.
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Host write: strobe low 4 cycles, address and data held 4 cycles past the rise.
    task automatic wr(input logic [1:0] a, input logic [7:0] dv);
        cs_n = 1'h0;
        addr = a;
        din = dv;
        iow_n = 1'h0;
        idle(4);
        iow_n = 1'h1;
        idle(4);
        cs_n = 1'h1;
        idle(4);
    endtask
    // Host read: data is taken once the synchronised strobe has been answered.
    task automatic rd(input logic [1:0] a, output logic [7:0] q);
        cs_n = 1'h0;
        addr = a;
        ior_n = 1'h0;
        idle(5);
        q = dout;
        check({7'h00, dout_oe}, 8'h01);
        ior_n = 1'h1;
        cs_n = 1'h1;
        idle(5);
        check({7'h00, dout_oe}, 8'h00);
    endtask
    function automatic logic [7:0] exp_sts(input logic [4:0] s, input logic pend);
        return {~s[4], s[3:0], ~pend, 2'h3};
    endfunction
    function automatic logic [7:0] exp_hs(input logic [7:0] c);
        return {4'h0, ~c[3], c[2], ~c[1], ~c[0]};
    endfunction
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    // A hang is cut short well beyond the expected run length.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        nrst = 1'h0;
        cs_n = 1'h1;
        iow_n = 1'h1;
        ior_n = 1'h1;
        addr = 2'h0;
        din = 8'h00;
        dir_pin = 1'h0;
        void'($urandom(55035));
        idle(2);
        nrst = 1'h1;
        idle(3);
        check(pd_out, 8'h00);
        check({5'h00, pd_oe, pd_oe2, irq}, 8'h06);
        check({4'h0, hs}, 8'h0B);
        check({7'h00, irq2}, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'hC0 : (i == 1) ? 8'hDF : 8'($urandom);
            wr(2'h2, v);
            check({4'h0, hs}, exp_hs(v));
            check({7'h00, irq}, 8'h00);
            rd(2'h2, rd_val);
            check(rd_val, {3'h7, v[4:0]});
            check(dout2, {3'h7, v[4:0]});
        end
        rd(2'h3, rd_val);
        check(rd_val, 8'hFF);
        // A write to the unmapped address must leave the control pins alone.
        wr(2'h3, ~v);
        check({4'h0, hs}, exp_hs(v));
        v = 8'($urandom);
        wr(2'h0, v);
        check(pd_out, v);
        $display("control test done");
        wr(2'h1, 8'hAA);
        wr(2'h1, 8'h12);
        check({6'h00, pd_oe, pd_oe2}, 8'h01);
        v = 8'($urandom);
        printer_model_inst.present(v);
        idle(2);
        rd(2'h0, rd_val);
        check(rd_val, v);
        wr(2'h1, 8'h55);
        check({6'h00, pd_oe, pd_oe2}, 8'h03);
        dir_pin = 1'h1;
        wr(2'h2, 8'h20);
        check({6'h00, pd_oe, pd_oe2}, 8'h00);
        wr(2'h2, 8'h00);
        check({6'h00, pd_oe, pd_oe2}, 8'h02);
        dir_pin = 1'h0;
        idle(4);
        $display("direction test done");
        for (int i = 0; i < 6; i++) begin
            printer_model_inst.set_status((i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom));
            idle(3);
            rd(2'h1, rd_val);
            check(rd_val, exp_sts(sts, 1'h0));
        end
        $display("status test done");
        wr(2'h2, 8'h10);
        printer_model_inst.set_ack(1'h0);
        idle(5);
        check({7'h00, irq}, 8'h01);
        check({7'h00, irq2}, 8'h01);
        rd(2'h1, rd_val);
        check(rd_val, exp_sts(sts, 1'h1));
        check({7'h00, irq2}, 8'h00);
        check({7'h00, irq}, 8'h00);
        printer_model_inst.set_ack(1'h1);
        idle(3);
        rd(2'h1, rd_val);
        check(rd_val, exp_sts(sts, 1'h0));
        wr(2'h2, 8'h00);
        printer_model_inst.set_ack(1'h0);
        idle(5);
        check({7'h00, irq}, 8'h00);
        printer_model_inst.set_ack(1'h1);
        wr(2'h2, 8'h10);
        check({7'h00, irq}, 8'h01);
        rd(2'h1, rd_val);
        check({5'h00, rd_val[2], irq}, 8'h00);
        $display("interrupt test done");
        wrap_up();
    end
endmodule
